// ### verilog/smr_pkg.sv
// package: field layout, sizes and link states of the serial read path
// Functional notes
// - direction bit 1 in target byte means read
// - start location is block select over latch
// - first data bit driven right after address
// - current read continues after previous location
// - counter increments after every byte sent
// - acknowledged byte is followed by next byte
// - unterminated read keeps driving further data
// - location 7FFh wraps to 000h
// - write-direction target then word address loads latch
// - repeated start turns it into current read
// - each byte sent wears its own 8-byte row once
// - target byte: type, block select, direction
// - increment happens just before acknowledge slot
// - start aborts and awaits new target address
// - stop aborts and returns to idle
package smr_pkg;
   // memory geometry
   localparam int unsigned ADDR_W   = 11;
   localparam int unsigned LO_W     = 8;
   localparam int unsigned BLK_W    = 3;
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned ROW_LSB  = 3;
   localparam int unsigned ROW_W    = ADDR_W - ROW_LSB;
   localparam int unsigned MEM_DEPTH = 1 << ADDR_W;
   localparam int unsigned ROW_DEPTH = 1 << ROW_W;
   // target byte fields
   localparam int unsigned TYPE_MSB = 7;
   localparam int unsigned TYPE_LSB = 4;
   localparam int unsigned BLK_MSB  = 3;
   localparam int unsigned BLK_LSB  = 1;
   localparam int unsigned RW_BIT   = 0;
   localparam logic        RW_READ  = 1'b1;
   // bit counter and reset values
   localparam logic [2:0]        BIT_LAST  = 3'h7;
   localparam logic [2:0]        BIT_FIRST = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 11'h000;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 11'h001;
   localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
   // event toggles passed from link to core
   localparam int unsigned EV_W     = 3;
   localparam int unsigned EV_ADDR  = 0;
   localparam int unsigned EV_WADDR = 1;
   localparam int unsigned EV_BYTE  = 2;
   // link-side states, one-hot
   typedef enum logic [6:0] {
      LK_ADDR      = 7'b0000001,
      LK_ADDR_ACK  = 7'b0000010,
      LK_WADDR     = 7'b0000100,
      LK_WADDR_ACK = 7'b0001000,
      LK_RD        = 7'b0010000,
      LK_RD_ACK    = 7'b0100000,
      LK_IDLE      = 7'b1000000
   } smr_lk_st_t;
endpackage

// ### verilog/smr_sync.sv
// two-stage synchroniser for levels and toggles
`timescale 1ns/100ps
`default_nettype none
module smr_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // smr_sync
`default_nettype wire

// ### verilog/smr_read_path.sv
// serial memory target: read path, address latch, row wear count
`timescale 1ns/100ps
`default_nettype none
module smr_read_path
   import smr_pkg::*;
#(
   parameter logic [3:0]  DEV_TYPE = 4'h5, // arbitrary device type
   parameter int unsigned WEAR_W   = 16
) (
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               clk_en,
   input  wire logic               scl_clk,
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output logic                    sda_o,
   output logic                    sda_oe,
   input  wire logic               fill_en,
   input  wire logic [ADDR_W-1:0]  fill_addr,
   input  wire logic [BYTE_W-1:0]  fill_data,
   output logic      [ADDR_W-1:0]  addr_latch,
   output logic      [ROW_W-1:0]   wear_row,
   output logic      [WEAR_W-1:0]  wear_count,
   output logic                    wear_pulse
);
   localparam logic [WEAR_W-1:0] WEAR_MAX = '1;
   localparam logic [WEAR_W-1:0] WEAR_ONE = WEAR_W'(1);

   // core domain state
   logic [BYTE_W-1:0] mem [MEM_DEPTH];
   logic [WEAR_W-1:0] wear_mem [ROW_DEPTH];
   logic [BYTE_W-1:0] rd_word;
   logic [1:0]        pin_s;
   logic              scl_s;
   logic              sda_s;
   logic              sda_d;
   logic              next_sda_d;
   logic [EV_W-1:0]   ev_s;
   logic [EV_W-1:0]   ev_seen;
   logic [EV_W-1:0]   next_ev_seen;
   logic [EV_W-1:0]   ev_hit;
   logic              framed;
   logic              next_framed;
   logic              link_hold;
   logic              next_link_hold;
   logic [ADDR_W-1:0] next_addr_latch;
   logic [ROW_W-1:0]  next_wear_row;
   logic [WEAR_W-1:0] next_wear_count;
   logic              next_wear_pulse;
   logic              start_seen;
   logic              stop_seen;

   // link domain state
   logic              lk_rst;
   logic              lk_en;
   smr_lk_st_t        lk_st;
   smr_lk_st_t        next_lk_st;
   logic [2:0]        lk_cnt;
   logic [2:0]        next_lk_cnt;
   logic [BYTE_W-1:0] lk_rx;
   logic [BYTE_W-1:0] next_lk_rx;
   logic [BYTE_W-1:0] lk_tx;
   logic [BYTE_W-1:0] next_lk_tx;
   logic [BLK_W-1:0]  lk_blk;
   logic [BLK_W-1:0]  next_lk_blk;
   logic              lk_rw;
   logic              next_lk_rw;
   logic [LO_W-1:0]   lk_waddr;
   logic [LO_W-1:0]   next_lk_waddr;
   logic [EV_W-1:0]   lk_tg;
   logic [EV_W-1:0]   next_lk_tg;
   logic              next_sda_oe;

   // bus pins into the core clock, idle level high
   smr_sync #(
      .W       (2),
      .RST_VAL (2'h3)
   ) u_pin_sync (
      .clk (core_clk),
      .rst (sys_rst),
      .d   ({scl_i, sda_i}),
      .q   (pin_s)
   );
   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   // link events into the core clock
   smr_sync #(
      .W       (EV_W),
      .RST_VAL (3'h0)
   ) u_ev_sync (
      .clk (core_clk),
      .rst (sys_rst),
      .d   (lk_tg),
      .q   (ev_s)
   );

   // clock enable into the link clock
   smr_sync #(
      .W       (1),
      .RST_VAL (1'h1)
   ) u_en_sync (
      .clk (scl_clk),
      .rst (sys_rst),
      .d   (clk_en),
      .q   (lk_en)
   );

   // link logic except the toggles is held cleared between frames and on every condition
   assign lk_rst = sys_rst | link_hold;

   // start and stop seen as data edges while the clock is high
   assign start_seen = scl_s & sda_d & ~sda_s;
   assign stop_seen  = scl_s & ~sda_d & sda_s;
   assign ev_hit     = ev_s ^ ev_seen;

   // core next values: frame tracking, latch, wear accounting
   always_comb
   begin
      next_sda_d      = sda_d;
      next_ev_seen    = ev_seen;
      next_framed     = framed;
      next_link_hold  = link_hold;
      next_addr_latch = addr_latch;
      next_wear_row   = wear_row;
      next_wear_count = wear_count;
      next_wear_pulse = 1'b0;
      if (clk_en)
      begin
         next_sda_d   = sda_s;
         next_ev_seen = ev_s;
         if (start_seen)
         begin
            next_framed    = 1'b1;
            next_link_hold = 1'b1;
         end
         else if (stop_seen)
         begin
            next_framed    = 1'b0;
            next_link_hold = 1'b1;
         end
         else if (framed && !scl_s)
         begin
            // release only while the clock is low, far from its edges
            next_link_hold = 1'b0;
         end
         if (ev_hit[EV_WADDR])
         begin
            next_addr_latch = {lk_blk, lk_waddr};
         end
         else if (ev_hit[EV_ADDR])
         begin
            next_addr_latch = {lk_blk, addr_latch[LO_W-1:0]};
         end
         else if (ev_hit[EV_BYTE])
         begin
            // natural roll from the top location to zero
            next_addr_latch = addr_latch + ADDR_STEP;
            next_wear_row   = addr_latch[ADDR_W-1:ROW_LSB];
            next_wear_pulse = 1'b1;
            if (wear_mem[addr_latch[ADDR_W-1:ROW_LSB]] == WEAR_MAX)
            begin
               next_wear_count = WEAR_MAX;   // saturate, never wrap
            end
            else
            begin
               next_wear_count =
                  wear_mem[addr_latch[ADDR_W-1:ROW_LSB]] + WEAR_ONE;
            end
         end
      end
   end

   // core registers
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sda_d      <= 1'b1;
         ev_seen    <= 3'h0;
         framed     <= 1'b0;
         link_hold  <= 1'b1;
         addr_latch <= ADDR_RST;
         wear_row   <= '0;
         wear_count <= '0;
         wear_pulse <= 1'b0;
         sda_o      <= 1'b0;
      end
      else
      begin
         sda_d      <= next_sda_d;
         ev_seen    <= next_ev_seen;
         framed     <= next_framed;
         link_hold  <= next_link_hold;
         addr_latch <= next_addr_latch;
         wear_row   <= next_wear_row;
         wear_count <= next_wear_count;
         wear_pulse <= next_wear_pulse;
         sda_o      <= 1'b0;             // open drain: only ever pulls low
      end
   end

   // wear table, one counter per 8-byte row
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < ROW_DEPTH; i++)
         begin
            wear_mem[i] <= '0;
         end
      end
      else if (next_wear_pulse)
      begin
         wear_mem[next_wear_row] <= next_wear_count;
      end
   end

   // array fill port and read word that follows the latch while clock enable is high;
   // the word settles within a few core cycles of each latch change,
   // well ahead of the link edge that loads it
   always_ff @(posedge core_clk)
   begin
      if (clk_en)
      begin
         if (fill_en)
         begin
            mem[fill_addr] <= fill_data;
         end
         rd_word <= mem[addr_latch];
      end
   end

   // link next values: shift in, decode, shift out
   always_comb
   begin
      next_lk_st    = lk_st;
      next_lk_cnt   = lk_cnt;
      next_lk_rx    = lk_rx;
      next_lk_tx    = lk_tx;
      next_lk_blk   = lk_blk;
      next_lk_rw    = lk_rw;
      next_lk_waddr = lk_waddr;
      next_lk_tg    = lk_tg;
      if (lk_en)
      begin
         case (lk_st)
            LK_ADDR:
            begin
               next_lk_rx  = {lk_rx[BYTE_W-2:0], sda_i};
               next_lk_cnt = lk_cnt + 3'h1;
               if (lk_cnt == BIT_LAST)
               begin
                  next_lk_cnt = BIT_FIRST;
                  if (next_lk_rx[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
                  begin
                     next_lk_st  = LK_ADDR_ACK;
                     next_lk_blk = next_lk_rx[BLK_MSB:BLK_LSB];
                     next_lk_rw  = next_lk_rx[RW_BIT];
                     if (next_lk_rx[RW_BIT] == RW_READ)
                     begin
                        next_lk_tg[EV_ADDR] = ~lk_tg[EV_ADDR];
                     end
                  end
                  else
                  begin
                     next_lk_st = LK_IDLE;
                  end
               end
            end
            LK_ADDR_ACK:
            begin
               next_lk_cnt = BIT_FIRST;
               if (lk_rw == RW_READ)
               begin
                  next_lk_st = LK_RD;
                  next_lk_tx = rd_word;
               end
               else
               begin
                  next_lk_st = LK_WADDR;
               end
            end
            LK_WADDR:
            begin
               next_lk_rx  = {lk_rx[BYTE_W-2:0], sda_i};
               next_lk_cnt = lk_cnt + 3'h1;
               if (lk_cnt == BIT_LAST)
               begin
                  next_lk_cnt            = BIT_FIRST;
                  next_lk_waddr          = next_lk_rx;
                  next_lk_tg[EV_WADDR]   = ~lk_tg[EV_WADDR];
                  next_lk_st             = LK_WADDR_ACK;
               end
            end
            LK_WADDR_ACK:
            begin
               // write data is not taken; a repeated start follows
               next_lk_st = LK_IDLE;
            end
            LK_RD:
            begin
               next_lk_tx  = {lk_tx[BYTE_W-2:0], 1'b0};
               next_lk_cnt = lk_cnt + 3'h1;
               if (lk_cnt == BIT_LAST)
               begin
                  next_lk_cnt        = BIT_FIRST;
                  next_lk_st         = LK_RD_ACK;
                  next_lk_tg[EV_BYTE] = ~lk_tg[EV_BYTE];
               end
            end
            LK_RD_ACK:
            begin
               if (!sda_i)
               begin
                  // acknowledged: keep going, even into a collision
                  next_lk_st = LK_RD;
                  next_lk_tx = rd_word;
               end
               else
               begin
                  next_lk_st = LK_IDLE;
               end
            end
            LK_IDLE:
            begin
               next_lk_st = LK_IDLE;
            end
            default:
            begin
               next_lk_st = LK_IDLE;
            end
         endcase
      end
   end

   // link registers, cleared by every start and stop
   always_ff @(posedge scl_clk or posedge lk_rst)
   begin
      if (lk_rst)
      begin
         lk_st    <= LK_ADDR;
         lk_cnt   <= BIT_FIRST;
         lk_rx    <= BYTE_RST;
         lk_tx    <= BYTE_RST;
         lk_blk   <= '0;
         lk_rw    <= 1'b0;
         lk_waddr <= BYTE_RST;
      end
      else
      begin
         lk_st    <= next_lk_st;
         lk_cnt   <= next_lk_cnt;
         lk_rx    <= next_lk_rx;
         lk_tx    <= next_lk_tx;
         lk_blk   <= next_lk_blk;
         lk_rw    <= next_lk_rw;
         lk_waddr <= next_lk_waddr;
      end
   end

   // toggles survive the link clear so the core never sees a false event
   always_ff @(posedge scl_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lk_tg <= 3'h0;
      end
      else
      begin
         lk_tg <= next_lk_tg;
      end
   end

   // pull-down enable: acks and zero data bits, released in read ack slots
   always_comb
   begin
      next_sda_oe = sda_oe;
      if (lk_en)
      begin
         next_sda_oe = (lk_st == LK_ADDR_ACK) ||
                       (lk_st == LK_WADDR_ACK) ||
                       ((lk_st == LK_RD) && !lk_tx[BYTE_W-1]);
      end
   end

   // data line drive changes on the bus clock fall; a link clear releases it at any time
   always_ff @(negedge scl_clk or posedge lk_rst)
   begin
      if (lk_rst)
      begin
         sda_oe <= 1'b0;
      end
      else
      begin
         sda_oe <= next_sda_oe;
      end
   end
endmodule // smr_read_path
`default_nettype wire

// ### dv/smr_read_path_chk.sv
// checker: port-level properties of the serial read path
`timescale 1ns/100ps
`default_nettype none
module smr_read_path_chk
   import smr_pkg::*;
#(
   parameter int unsigned WEAR_W = 16
) (
   input wire logic              core_clk,
   input wire logic              sys_rst,
   input wire logic              scl_i,
   input wire logic              sda_i,
   input wire logic              sda_o,
   input wire logic              sda_oe,
   input wire logic [ROW_W-1:0]  wear_row,
   input wire logic [WEAR_W-1:0] wear_count,
   input wire logic              wear_pulse
);
   // everything is judged in the core domain
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // open drain: the pin only ever pulls low
   a_pull_low: assert property (sda_oe |-> !sda_o)
      else $error("data pin driven high");
   // new data only appears while the clock is low
   a_drive_low: assert property ($rose(sda_oe) |-> !scl_i)
      else $error("drive started with clock high");
   // with the clock high the pin may only be let go
   a_high_release: assert property (
      $changed(sda_oe) && scl_i |-> !sda_oe)
      else $error("drive changed with clock high");
   // a start condition frees the line within a few cycles
   a_start_clear: assert property (
      scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] !sda_oe)
      else $error("line held after start");
   // a stop frees the line and keeps it free for eight cycles
   a_stop_quiet: assert property (
      scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:5] !sda_oe [*8])
      else $error("line held after stop");
   // one wear update per byte, never two in a row
   a_pulse_single: assert property (wear_pulse |=> !wear_pulse)
      else $error("wear pulse too long");
   a_row_moves: assert property ($changed(wear_row) |-> wear_pulse)
      else $error("wear row moved without a byte");
   a_count_moves: assert property (
      $changed(wear_count) |-> wear_pulse)
      else $error("wear count moved without a byte");

   c_byte: cover property (wear_pulse);
   c_drive: cover property ($rose(sda_oe));
   c_stop: cover property (scl_i && $past(scl_i) && $rose(sda_i));
endmodule // smr_read_path_chk

bind smr_read_path smr_read_path_chk #(.WEAR_W(WEAR_W)) smr_read_path_chk_i (
   .core_clk   (core_clk),
   .sys_rst    (sys_rst),
   .scl_i      (scl_i),
   .sda_i      (sda_i),
   .sda_o      (sda_o),
   .sda_oe     (sda_oe),
   .wear_row   (wear_row),
   .wear_count (wear_count),
   .wear_pulse (wear_pulse)
);
`default_nettype wire

// ### dv/smr_ctl_model.sv
// partner model: two-wire bus controller that issues reads
`timescale 1ns/100ps
`default_nettype none
module smr_ctl_model (
   output logic     scl,
   output logic     sda_drv,
   input wire logic sda
);
   // bus idle: both lines high
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // start or repeated start; clock left low afterwards
   task automatic start_c();
      #7;
      sda_drv = 1'b1;
      #40 scl = 1'b1;
      #40 sda_drv = 1'b0;
      #80 scl = 1'b0;
   endtask

   // stop from clock low; the clock then stands high
   task automatic stop_c();
      sda_drv = 1'b0;
      #40 scl = 1'b1;
      #40 sda_drv = 1'b1;
      #80;
   endtask

   // one bit: set data in the low phase, sample at the rise
   task automatic bit_c(input logic v, output logic s);
      #20 sda_drv = v;
      #60 scl = 1'b1;
      s = sda;
      #80 scl = 1'b0;
   endtask

   // byte out, msb first, then the target's acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_c(b[i], s);
      bit_c(1'b1, s);
      ack = ~s;
   endtask

   // byte in; the acknowledge slot is left to the caller
   task automatic recv(output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         bit_c(1'b1, b[i]);
   endtask
endmodule // smr_ctl_model
`default_nettype wire

// ### dv/smr_read_path_tb.sv
// testbench: selective, current, wrapping and aborted reads
`timescale 1ns/100ps
`default_nettype none
module smr_read_path_tb;
   import smr_pkg::*;
   localparam logic [3:0] DEV_T = 4'h5; // arbitrary type code
   logic                core_clk = 1'b0;
   logic                sys_rst;
   logic                clk_en;
   logic                fill_en;
   logic [ADDR_W-1:0]   fill_addr;
   logic [BYTE_W-1:0]   fill_data;
   logic                scl;
   logic                ctl_sda;
   wire logic           sda;
   logic                sda_o;
   logic                sda_oe;
   logic [ADDR_W-1:0]   addr_latch;
   logic [ADDR_W-1:0]   loc;
   logic [ROW_W-1:0]    wear_row;
   logic [ROW_W-1:0]    exp_row;
   logic [15:0]         wear_count;
   logic                wear_pulse;
   int                  num_errors = 0;
   int                  check_count = 0;
   int unsigned         wear_tab [ROW_DEPTH];
   logic [ROW_W-1:0]    row_q [$];

   // wired-and bus with pull-up
   assign sda = ctl_sda & (sda_oe ? sda_o : 1'b1);
   always #10 core_clk = ~core_clk;

   smr_ctl_model smr_ctl_model_i (.scl(scl), .sda_drv(ctl_sda), .sda(sda));
   smr_read_path #(.DEV_TYPE(DEV_T), .WEAR_W(16)) smr_read_path_i (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .scl_clk(scl), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .fill_en(fill_en), .fill_addr(fill_addr),
      .fill_data(fill_data), .addr_latch(addr_latch),
      .wear_row(wear_row), .wear_count(wear_count),
      .wear_pulse(wear_pulse));

   // array content pattern differs per block
   function automatic logic [7:0] pat(input logic [10:0] a);
      return a[7:0] ^ {a[10:8], a[10:8], 2'h2};
   endfunction

   task automatic chk_b(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t %s got %b", $time, what, got);
      end
   endtask

   task automatic chk_v(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // every byte sent must wear its own row once; negedge sees settled values
   always @(negedge core_clk)
   begin
      if (wear_pulse === 1'b1)
      begin
         chk_b(row_q.size() > 0, 1'b1, "wear pulse expected");
         if (row_q.size() > 0)
            exp_row = row_q.pop_front();
         wear_tab[exp_row]++;
         chk_v(16'(wear_row), 16'(exp_row), "wear row");
         chk_v(wear_count, 16'(wear_tab[exp_row]), "wear count");
      end
   end

   // load the latch with a truncated write
   task automatic set_addr(input logic [2:0] blk, input logic [7:0] w);
      logic ack;
      @(negedge core_clk);
      smr_ctl_model_i.start_c();
      smr_ctl_model_i.send({DEV_T, blk, 1'b0}, ack);
      chk_b(ack, 1'b1, "write target ack");
      smr_ctl_model_i.send(w, ack);
      chk_b(ack, 1'b1, "word address ack");
      loc = {blk, w};
   endtask

   // read n bytes; term 0 nack+stop, 1 nack+start, 2 stop, 3 start
   task automatic rd_n(input logic [2:0] blk, input int n, input int term);
      logic       ack;
      logic       s;
      logic [7:0] b;
      @(negedge core_clk);
      smr_ctl_model_i.start_c();
      smr_ctl_model_i.send({DEV_T, blk, RW_READ}, ack);
      chk_b(ack, 1'b1, "read target ack");
      loc = {blk, loc[7:0]};
      for (int i = 0; i < n; i++)
      begin
         row_q.push_back(loc[10:3]);
         smr_ctl_model_i.recv(b);
         chk_v(16'(b), 16'(pat(loc)), "read byte");
         loc = loc + 11'h001;
         if (i < n - 1)
            smr_ctl_model_i.bit_c(1'b0, s);
      end
      if (term < 2)
         smr_ctl_model_i.bit_c(1'b1, s);
      if (term == 1 || term == 3)
         smr_ctl_model_i.start_c();
      smr_ctl_model_i.stop_c();
      #200;
      chk_b(sda_oe, 1'b0, "line released");
      chk_v(16'(addr_latch), 16'(loc), "address latch");
   endtask

   // selective read crossing a block boundary
   task automatic s_selective();
      set_addr(3'h2, 8'hFE);
      rd_n(3'h2, 4, 0);
   endtask

   // current read under another block select
   task automatic s_current();
      rd_n(3'h5, 2, 1);
   endtask

   // top location wraps; stop in the acknowledge slot
   task automatic s_wrap();
      set_addr(3'h7, 8'hFE);
      rd_n(3'h7, 3, 2);
   endtask

   // clock enable low freezes the array port and the latch
   task automatic s_freeze();
      @(negedge core_clk);
      clk_en = 1'b0;
      fill_en = 1'b1;
      fill_addr = loc;
      fill_data = ~pat(loc);
      repeat (4) @(negedge core_clk);
      fill_en = 1'b0;
      chk_v(16'(addr_latch), 16'(loc), "latch frozen");
      @(negedge core_clk);
      clk_en = 1'b1;
      // the fill was ignored, so the old content must come back
      rd_n(loc[10:8], 1, 0);
   endtask

   // start in the acknowledge slot aborts
   task automatic s_start9();
      rd_n(3'h0, 2, 3);
   endtask

   // foreign type code gets no acknowledge
   task automatic s_bad_type();
      logic ack;
      @(negedge core_clk);
      smr_ctl_model_i.start_c();
      smr_ctl_model_i.send({~DEV_T, 3'h0, RW_READ}, ack);
      chk_b(ack, 1'b0, "foreign type refused");
      smr_ctl_model_i.stop_c();
      chk_v(16'(addr_latch), 16'(loc), "latch kept");
   endtask

   // cut a hang short
   initial
   begin
      repeat (100000) @(posedge core_clk);
      num_errors++;
      conclude();
   end

   // reset, fill the array, then the scenarios over several rows
   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      fill_en = 1'b0;
      fill_addr = '0;
      fill_data = '0;
      loc = '0;
      repeat (10) @(negedge core_clk);
      sys_rst = 1'b0;
      chk_v(16'(addr_latch), 16'h0000, "latch after reset");
      for (int a = 0; a < MEM_DEPTH; a++)
      begin
         @(negedge core_clk);
         fill_en = 1'b1;
         fill_addr = a[10:0];
         fill_data = pat(a[10:0]);
      end
      @(negedge core_clk);
      fill_en = 1'b0;
      s_selective();
      s_current();
      s_wrap();
      s_start9();
      s_bad_type();
      s_freeze();
      chk_v(16'(row_q.size()), 16'h0000, "wear pulses missing");
      conclude();
   end
endmodule // smr_read_path_tb
`default_nettype wire
